// >>> include/ppcfg_pkg.sv
// Package for the port pin configuration block: register map, layouts, resets.
// Assumes a 32-bit APB register bus, byte addresses word aligned.
package ppcfg_pkg;

  // ==========================================================================
  // Register indices (printed offsets) and address width
  localparam logic [11:0] PPCFG_IDX_DIR   = 12'h25a;
  localparam logic [11:0] PPCFG_IDX_DRV   = 12'h25b;
  localparam logic [11:0] PPCFG_IDX_PULL  = 12'h25c;
  localparam logic [11:0] PPCFG_IDX_POL   = 12'h25d;
  localparam logic [11:0] PPCFG_IDX_IEN   = 12'h25e;
  localparam logic [11:0] PPCFG_IDX_FLAG  = 12'h25f;
  localparam logic [11:0] PPCFG_IDX_OVR   = 12'h260;
  localparam logic [11:0] PPCFG_IDX_STAT  = 12'h261;
  localparam int          PPCFG_ADDR_W    = 14;

  // ==========================================================================
  // Field positions and reset values
  localparam int         PPCFG_PIN_SHDN  = 7;
  localparam int         PPCFG_PIN_SER_A = 0;
  localparam int         PPCFG_PIN_SER_B = 2;
  localparam int         PPCFG_PIN_TMR_C = 1;
  localparam logic [7:0] PPCFG_RST_DIR   = 8'h00;
  localparam logic [7:0] PPCFG_RST_DRV   = 8'h00;
  localparam logic [7:0] PPCFG_RST_PULL  = 8'h00;
  localparam logic [7:0] PPCFG_RST_POL   = 8'h00;
  localparam logic [7:0] PPCFG_RST_IEN   = 8'h00;
  localparam logic [7:0] PPCFG_RST_FLAG  = 8'h00;

  // ==========================================================================
  // Per-pin pad controls carried together
  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] reduced;
    logic [7:0] pull_on;
    logic [7:0] pull_down;
  } ppcfg_pad_t;

  // Peripheral override requests
  typedef struct packed {
    logic [7:0] pwm_en;
    logic       pwm_shdn;
    logic [7:0] tmr_oc_en;
    logic [7:0] ser_en;
    logic [7:0] ser_out;
  } ppcfg_ovr_t;

endpackage : ppcfg_pkg

// >>> rtl/ppcfg_top.sv
// Port P pin configuration: direction, drive, pull, polarity, edge interrupts.
// Assumes an APB master on I_CORE_CLK; pins and peripheral requests arrive asynchronously.
// What this block does
// R1 - A direction bit of 1 makes its pin an output and 0 an input unless overridden.
// R2 - An enabled modulator channel forces its pin to output, except pin 7 while shutdown is enabled.
// R3 - Overrides never change the stored direction bits.
// R4 - With modulator shutdown enabled, pin 7 is forced to input.
// R5 - On pins 2 and 0 an enabled timer compare forces output when no modulator owns the pin.
// R6 - On pins 2 and 0 an enabled serial interface sets the direction when nothing else owns it.
// R7 - Pin 1 takes modulator, then timer, then its direction bit; serial has no effect.
// R8 - A drive bit of 1 selects reduced drive, 0 full drive.
// R9 - Drive selection applies to any owner and has no effect on an input.
// R10 - A pull-enable bit of 1 turns on the pull device with direction from polarity.
// R11 - An output pin never has its pull device applied.
// R12 - Polarity 1 means pull-down and rising edge, 0 pull-up and falling edge.
// R13 - All configuration registers are readable and writable at any time.
// R14 - Reset clears direction and drive registers.
// R15 - An active edge sets the pin flag; writing 1 clears it.
// R16 - The enable bit passes or masks each pin's edge interrupt.
// R17 - The effective direction after overrides gates pull and drive.
//
// Implementation choice: register access over APB.
module ppcfg_top
  import ppcfg_pkg::*;
#(
  parameter int NPINS = 8
) (
  input  wire logic                    I_CORE_CLK,
  input  wire logic                    I_SYS_RST,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [PPCFG_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  input  wire logic [3:0]              i_pstrb,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic [7:0]              i_pin,
  input  wire ppcfg_ovr_t              i_ovr,
  output ppcfg_pad_t                   o_pad,
  output logic                         o_irq
);

  // ==========================================================================
  // Elaboration check
  if (NPINS != 8) begin : g_bad_npins
    $error("ppcfg_top serves eight pins only");
  end

  logic [7:0] port_direction;
  logic [7:0] port_drive_strength;
  logic [7:0] port_pull_enable;
  logic [7:0] port_pull_and_edge_polarity;
  logic [7:0] port_edge_irq_enable;
  logic [7:0] port_edge_flag;
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_d;
  ppcfg_ovr_t ovr_s1;
  ppcfg_ovr_t ovr_s2;
  logic [7:0] eff_out;
  logic [7:0] edge_hit;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic       lane0;
  logic [11:0] idx;

  // ==========================================================================
  // Input synchronisers
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_d  <= 8'h00;
      ovr_s1 <= '0;
      ovr_s2 <= '0;
    end else begin
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
      ovr_s1 <= i_ovr;
      ovr_s2 <= ovr_s1;
    end
  end

  // ==========================================================================
  // Effective direction per pin
  always_comb begin
    // R1 direction bit default
    // R3 stored bits untouched
    eff_out = port_direction;
    for (int p = 0; p < 8; p++) begin
      if ((p == PPCFG_PIN_SER_A) || (p == PPCFG_PIN_SER_B)) begin
        // R6 serial claims pin
        if (ovr_s2.ser_en[p]) begin
          eff_out[p] = ovr_s2.ser_out[p];
        end
      end
      if ((p == PPCFG_PIN_SER_A) || (p == PPCFG_PIN_SER_B) || (p == PPCFG_PIN_TMR_C)) begin
        // R5 timer compare output
        // R7 pin 1 priority
        if (ovr_s2.tmr_oc_en[p]) begin
          eff_out[p] = 1'b1;
        end
      end
      // R2 modulator forces output
      if (ovr_s2.pwm_en[p]) begin
        eff_out[p] = 1'b1;
      end
    end
    // R4 shutdown forces input
    if (ovr_s2.pwm_shdn) begin
      eff_out[PPCFG_PIN_SHDN] = 1'b0;
    end
  end

  // ==========================================================================
  // APB decode
  // Write lands once, on the ready edge, and only at a mapped aligned word
  assign acc   = i_psel && i_penable;
  assign wr    = acc && i_pwrite && hit && o_pready;
  assign rd    = acc && !i_pwrite;
  assign lane0 = i_pstrb[0];
  assign idx   = i_paddr[PPCFG_ADDR_W-1:2];
  assign hit   = (i_paddr[1:0] == 2'b00) &&
                 (idx >= PPCFG_IDX_DIR) && (idx <= PPCFG_IDX_STAT);

  // R13 configuration registers, any time
  // R14 reset clears direction and drive
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      port_direction              <= PPCFG_RST_DIR;
      port_drive_strength         <= PPCFG_RST_DRV;
      port_pull_enable            <= PPCFG_RST_PULL;
      port_pull_and_edge_polarity <= PPCFG_RST_POL;
      port_edge_irq_enable        <= PPCFG_RST_IEN;
    end else if (wr && lane0) begin
      unique case (idx)
        PPCFG_IDX_DIR:  port_direction              <= i_pwdata[7:0];
        PPCFG_IDX_DRV:  port_drive_strength         <= i_pwdata[7:0];
        PPCFG_IDX_PULL: port_pull_enable            <= i_pwdata[7:0];
        PPCFG_IDX_POL:  port_pull_and_edge_polarity <= i_pwdata[7:0];
        PPCFG_IDX_IEN:  port_edge_irq_enable        <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Edge detection and sticky flags
  // R12 polarity picks edge
  assign edge_hit = (port_pull_and_edge_polarity & pin_s2 & ~pin_d) |
                    (~port_pull_and_edge_polarity & ~pin_s2 & pin_d);

  // R15 set wins over clear
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      port_edge_flag <= PPCFG_RST_FLAG;
    end else if (wr && lane0 && (idx == PPCFG_IDX_FLAG)) begin
      port_edge_flag <= (port_edge_flag & ~i_pwdata[7:0]) | edge_hit;
    end else begin
      port_edge_flag <= port_edge_flag | edge_hit;
    end
  end

  // R16 enable masks request
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(port_edge_flag & port_edge_irq_enable);
    end
  end

  // ==========================================================================
  // Pad controls, registered
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      o_pad <= '0;
    end else begin
      o_pad.out_en    <= eff_out;
      // R8 reduced drive select
      // R9 R17 only while output
      o_pad.reduced   <= port_drive_strength & eff_out;
      // R10 R11 R17 pull on inputs only
      o_pad.pull_on   <= port_pull_enable & ~eff_out;
      // R12 pull direction
      o_pad.pull_down <= port_pull_and_edge_polarity;
    end
  end

  // ==========================================================================
  // APB answer: one wait state, ready on the access cycle's second edge
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc && !o_pready;
      o_pslverr <= acc && !o_pready && !hit;
      o_prdata  <= 32'h0000_0000;
      if (rd && !o_pready && hit) begin
        unique case (idx)
          PPCFG_IDX_DIR:  o_prdata[7:0] <= port_direction;
          PPCFG_IDX_DRV:  o_prdata[7:0] <= port_drive_strength;
          PPCFG_IDX_PULL: o_prdata[7:0] <= port_pull_enable;
          PPCFG_IDX_POL:  o_prdata[7:0] <= port_pull_and_edge_polarity;
          PPCFG_IDX_IEN:  o_prdata[7:0] <= port_edge_irq_enable;
          PPCFG_IDX_FLAG: o_prdata[7:0] <= port_edge_flag;
          PPCFG_IDX_OVR:  o_prdata[7:0] <= eff_out;
          PPCFG_IDX_STAT: o_prdata[7:0] <= pin_s2;
          default: ;
        endcase
      end
    end
  end

endmodule : ppcfg_top

// >>> testbench/ppcfg_props.sv
// Checker for the port pin block: bus handshake, pad gating, overrides.
// Assumes binding onto ppcfg_top; overrides held for at least five edges.
module ppcfg_props
  import ppcfg_pkg::*;
(
  input wire logic       I_CORE_CLK,
  input wire logic       I_SYS_RST,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       o_pready,
  input wire logic       o_pslverr,
  input wire ppcfg_ovr_t i_ovr,
  input wire ppcfg_pad_t o_pad
);
  // ====================
  // Properties
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  ready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("late ready");
  ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("long ready");
  err_ready_a: assert property (o_pslverr |-> o_pready) else $error("stray error");
  rst_clear_a: assert property ($fell(I_SYS_RST) |-> o_pad.out_en == 0 && o_pad.reduced == 0)
    else $error("pads after reset");
  drive_gate_a: assert property ((o_pad.reduced & ~o_pad.out_en) == 8'h00)
    else $error("drive on input");
  pull_gate_a: assert property ((o_pad.pull_on & o_pad.out_en) == 8'h00)
    else $error("pull on output");
  pwm_out_a: assert property (i_ovr.pwm_en[3] [*5] |-> o_pad.out_en[3])
    else $error("pwm pin");
  shdn_in_a: assert property (i_ovr.pwm_shdn [*5] |-> !o_pad.out_en[7])
    else $error("shutdown pin");
  tmr_out_a: assert property (i_ovr.tmr_oc_en[1] [*5] |-> o_pad.out_en[1])
    else $error("timer pin");
  ser_out_a: assert property ((i_ovr.ser_en[0] && i_ovr.ser_out[0]) [*5] |-> o_pad.out_en[0])
    else $error("serial pin");
  // Main scenarios reached
  cover property (o_pslverr);
  cover property (i_ovr.pwm_shdn && !o_pad.out_en[7]);
  cover property (o_pad.pull_on != 8'h00);
endmodule : ppcfg_props

bind ppcfg_top ppcfg_props i_props (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_ovr(i_ovr), .o_pad(o_pad));

// >>> testbench/ppcfg_ext.sv
// Far side model: board pin levels and on-chip peripheral requests.
// Assumes the bench sets levels and requests just after a rising edge.
module ppcfg_ext
  import ppcfg_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_lvl,
  input  wire ppcfg_ovr_t i_req,
  output logic [7:0]      o_pin = '0,
  output ppcfg_ovr_t      o_ovr = '0
);
  // ====================
  // Launch levels and requests at the edge
  always @(posedge i_clk) begin
    o_pin <= i_lvl;
    o_ovr <= i_req;
  end
endmodule : ppcfg_ext

// >>> testbench/tb_top.sv
// Bench for the port pin block: registers, overrides, pads, edge irq.
// Assumes the far side model feeds pins and requests; one 200 MHz clock.
module tb_top
  import ppcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        prdy, perr, irq;
  logic [13:0] padr = '0;
  logic [31:0] pwd = '0, prd;
  logic [3:0]  pstb = 4'hf;
  logic [7:0]  lvl = '0, pin, r [4];
  logic [33:0] q [$], em;
  ppcfg_ovr_t  req = '0, ovr;
  ppcfg_pad_t  pad, ep;
  int          num_errors = 0, num_checks = 0;
  // ====================
  // Clock, design, far side
  initial forever #2.5 clk = ~clk;
  ppcfg_top i_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(pstb), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .i_pin(pin), .i_ovr(ovr), .o_pad(pad), .o_irq(irq));
  ppcfg_ext i_ext (.i_clk(clk), .i_lvl(lvl), .i_req(req), .o_pin(pin), .o_ovr(ovr));
  // ====================
  // Helpers
  function automatic logic [11:0] ix(input int i);
    return 12'(PPCFG_IDX_DIR + i);
  endfunction : ix
  function automatic logic [33:0] rd(input logic [7:0] d);
    return {2'b10, 24'h0, d};
  endfunction : rd
  function automatic ppcfg_pad_t pad_exp(input logic [7:0] d, v, p, s, input ppcfg_ovr_t o);
    logic [7:0] e;
    e = d | o.pwm_en;
    for (int i = 0; i < 3; i++)
      if (!o.pwm_en[i] && o.tmr_oc_en[i]) e[i] = 1'b1;
      else if (!o.pwm_en[i] && i != 1 && o.ser_en[i]) e[i] = o.ser_out[i];
    if (o.pwm_shdn) e[7] = 1'b0;
    return {e, v & e, p & ~e, s};
  endfunction : pad_exp
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (e !== g) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // One APB transfer; its expected answer goes to the queue
  task automatic apb(input logic w, input logic [11:0] i, input logic [1:0] lo,
                     input logic [7:0] d, input logic [33:0] e);
    int n;
    q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {i, lo};
    pwd <= {24'($urandom), d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
    if (n == 20) num_errors++;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // Answer monitor against oldest note
  always @(posedge clk) begin
    if (prdy === 1'b1 && q.size() > 0) begin
      em = q.pop_front();
      chk(em, {em[33], perr, em[33] ? prd : em[31:0]});
    end
  end
  // Watchdog
  initial begin
    #50us;
    num_errors++;
    final_report();
  end
  // ====================
  // Tests
  initial begin
    void'($urandom(32'h78f94304));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) apb(1'b0, ix(i), 2'b00, 8'h00, rd(8'h00));
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      r[i] = 8'($urandom);
      apb(1'b1, ix(i), 2'b00, r[i], 34'h0);
      pstb <= 4'h0;
      apb(1'b1, ix(i), 2'b00, ~r[i], 34'h0);
      pstb <= 4'hf;
      apb(1'b0, ix(i), 2'b00, 8'h00, rd(r[i]));
    end
    apb(1'b0, 12'h300, 2'b00, 8'h00, {2'b11, 32'h0});
    apb(1'b1, ix(0), 2'b01, 8'hff, {2'b01, 32'h0});
    apb(1'b0, ix(0), 2'b00, 8'h00, rd(r[0]));
    $display("test register access done");
    repeat (40) begin
      for (int i = 0; i < 4; i++) begin
        r[i] = 8'($urandom);
        apb(1'b1, ix(i), 2'b00, r[i], 34'h0);
      end
      req <= {1'($urandom), 32'($urandom)};
      repeat (8) @(posedge clk);
      ep = pad_exp(r[0], r[1], r[2], r[3], req);
      chk({2'b0, ep}, {2'b0, pad});
      apb(1'b0, ix(0), 2'b00, 8'h00, rd(r[0]));
      apb(1'b0, PPCFG_IDX_OVR, 2'b00, 8'h00, rd(ep.out_en));
    end
    $display("test overrides done");
    apb(1'b1, PPCFG_IDX_POL, 2'b00, 8'h08, 34'h0);
    apb(1'b1, PPCFG_IDX_IEN, 2'b00, 8'h08, 34'h0);
    apb(1'b1, PPCFG_IDX_FLAG, 2'b00, 8'hff, 34'h0);
    lvl <= 8'h09;
    repeat (8) @(posedge clk);
    chk(34'h1, {33'h0, irq});
    apb(1'b0, PPCFG_IDX_FLAG, 2'b00, 8'h00, rd(8'h08));
    lvl <= 8'h00;
    repeat (8) @(posedge clk);
    apb(1'b0, PPCFG_IDX_FLAG, 2'b00, 8'h00, rd(8'h09));
    apb(1'b1, PPCFG_IDX_IEN, 2'b00, 8'h00, 34'h0);
    repeat (4) @(posedge clk);
    chk(34'h0, {33'h0, irq});
    apb(1'b1, PPCFG_IDX_FLAG, 2'b00, 8'h09, 34'h0);
    apb(1'b0, PPCFG_IDX_FLAG, 2'b00, 8'h00, rd(8'h00));
    $display("test edge flags done");
    final_report();
  end
endmodule : tb_top
